// >>> design/dcss_chan_filter.sv
// Synchroniser and stability qualifier for one safety channel
`include "dcss_defs.svh"
module dcss_chan_filter
    import dcss_pkg::*;
#(
    parameter int QUAL_CYCLES = `DCSS_QUAL_CYCLES
)(
    input wire logic core_clk_i, // Control clock
    input wire logic rstn_i, // Async reset, active low
    input wire logic closed_i, // Raw contact level, 1 = shorted
    output logic closed_o // Qualified level
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic [31:0] cnt;
    } dcss_filt_s;
    dcss_filt_s st;
    dcss_filt_s next_st;

    // Restart the count whenever the input agrees with the level, so short pulses die here
    always_comb
    begin
        next_st = st;
        next_st.sync1 = closed_i;
        next_st.sync2 = st.sync1;
        if (st.sync2 == st.level)
        begin
            next_st.cnt = 32'h0;
        end
        else if (st.cnt >= 32'(QUAL_CYCLES - 1))
        begin
            next_st.level = st.sync2;
            next_st.cnt = 32'h0;
        end
        else
        begin
            next_st.cnt = st.cnt + 32'h1;
        end
    end

    // Reset to open: the safe reading
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign closed_o = st.level;

    // Level only moves after a full qualification run
    a_filt_hold: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i)
        $changed(st.level) |-> $past(st.cnt) == 32'(QUAL_CYCLES - 1))
        else $error("qualified level changed early");
endmodule

// >>> design/dcss_defs.svh
// Timing constants and selection codes for the dual-channel safe stop
`ifndef DCSS_DEFS_SVH
`define DCSS_DEFS_SVH
`define DCSS_CLK_MHZ 100
`define DCSS_QUAL_TIME_US 2000
`define DCSS_QUAL_CYCLES (`DCSS_QUAL_TIME_US * `DCSS_CLK_MHZ)
`define DCSS_SEL_POS 8'h50
`define DCSS_SEL_NEG 8'hB4
`define DCSS_CODE_NONE 3'h0
`define DCSS_CODE_SAFE_STOP 3'h5
`define DCSS_CODE_FAULT0 3'h1
`endif

// >>> design/dcss_pkg.sv
// Types shared by the dual-channel safe stop design
package dcss_pkg;
    typedef enum logic [1:0] {
        DCSS_RUN = 2'h0,
        DCSS_STOP = 2'h1,
        DCSS_FAULT = 2'h3
    } dcss_mode_e;
    typedef struct packed {
        logic health;
        logic safe_stop;
        logic term;
        logic drive_en;
    } dcss_out_s;
    typedef struct packed {
        dcss_mode_e mode;
        dcss_out_s outs;
        logic [2:0] disp_code;
    } dcss_state_s;
endpackage

// >>> design/dcss_safe_stop.sv
// Decision logic of the dual-channel safety stop
//
// Operation
// - Drive enabled only: powered, both shorted, healthy
// - Safe status on open-open; health when healthy
// - Failure shows one of four fault codes
// - Both open and healthy shows safe-stop code
// - Channel change needs 2 ms stable hold
// - Terminal selects positive or negative safe status
`include "dcss_defs.svh"
module dcss_safe_stop
    import dcss_pkg::*;
#(
    parameter int QUAL_CYCLES = `DCSS_QUAL_CYCLES
)(
    input wire logic core_clk_i, // Control clock, 100 MHz
    input wire logic rstn_i, // Async reset, active low
    input wire logic power_ok_i, // Supply present
    input wire logic safety_channel_a_i, // 1 = shorted to channel_common
    input wire logic safety_channel_b_i, // 1 = shorted to channel_common
    input wire logic fault_i, // Internal safety-circuit failure
    input wire logic [1:0] fault_kind_i, // Which of four failures
    input wire logic [7:0] term_sel_i, // Terminal function selection
    output logic drive_en_o, // Drive output enable
    output logic safe_stop_indication_o, // Safe status, 1 = conducting
    output logic safety_health_status_o, // Health, 1 = conducting
    output logic term_o, // Configurable terminal, 1 = conducting
    output logic [2:0] safety_fault_code_o // Display code
);
    logic a_closed;
    logic b_closed;
    dcss_state_s st;
    dcss_state_s next_st;

    // All checks below sample on the control clock and sleep in reset, except a_reset_safe
    default clocking dcss_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // One filter per channel; the two are never compared, a mismatch
    // just leaves the drive stopped
    dcss_chan_filter #(.QUAL_CYCLES(QUAL_CYCLES)) u_fa (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .closed_i(safety_channel_a_i),
        .closed_o(a_closed)
    );
    dcss_chan_filter #(.QUAL_CYCLES(QUAL_CYCLES)) u_fb (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .closed_i(safety_channel_b_i),
        .closed_o(b_closed)
    );

    // Decision table; failure and power loss dominate everything
    always_comb
    begin
        next_st = '0;
        if (!power_ok_i)
        begin
            next_st.mode = DCSS_STOP; // Outputs off, but negative selection still turns the terminal on
        end
        else if (fault_i)
        begin
            next_st.mode = DCSS_FAULT;
            next_st.disp_code = `DCSS_CODE_FAULT0
                + {1'b0, fault_kind_i};
        end
        else if (a_closed && b_closed)
        begin
            next_st.mode = DCSS_RUN;
            next_st.outs.drive_en = 1'b1;
            next_st.outs.health = 1'b1;
        end
        else
        begin
            next_st.mode = DCSS_STOP;
            next_st.outs.health = 1'b1;
            if (!a_closed && !b_closed)
            begin
                next_st.outs.safe_stop = 1'b1;
                next_st.disp_code = `DCSS_CODE_SAFE_STOP;
            end
        end
        // Unknown selection leaves the terminal off; the sense is applied
        // after the decision, so both codes follow the same safe status
        case (term_sel_i)
            `DCSS_SEL_POS:
            begin
                next_st.outs.term = next_st.outs.safe_stop;
            end
            `DCSS_SEL_NEG:
            begin
                next_st.outs.term = !next_st.outs.safe_stop;
            end
            default:
            begin
                next_st.outs.term = 1'b0;
            end
        endcase
    end

    // Reset holds every output non-conducting and the drive off
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flops, so decode hazards
    // never reach the open-collector drivers
    assign drive_en_o = st.outs.drive_en;
    assign safe_stop_indication_o = st.outs.safe_stop;
    assign safety_health_status_o = st.outs.health;
    assign term_o = st.outs.term;
    assign safety_fault_code_o = st.disp_code;

    // Checks on the registered outputs; causes are judged one edge back
    // Drive may only follow a full set of good causes
    a_drive_cause: assert property (
        drive_en_o |-> $past(power_ok_i && !fault_i
        && a_closed && b_closed))
        else $error("drive enabled without cause");

    // Good causes must not be ignored either
    a_drive_on: assert property (
        (power_ok_i && !fault_i && a_closed && b_closed) |=> drive_en_o)
        else $error("drive not enabled");

    // Open-open while healthy: safe status on, drive off
    a_safe_cause: assert property (
        (power_ok_i && !fault_i && !a_closed && !b_closed)
        |=> safe_stop_indication_o && !drive_en_o)
        else $error("safe status missing");

    // Health conducts whenever powered without failure
    a_health_on: assert property (
        (power_ok_i && !fault_i) |=> safety_health_status_o)
        else $error("health status missing");

    // Failure or power loss turns both status outputs off
    a_health_off: assert property (
        (fault_i || !power_ok_i) |=> !safety_health_status_o
        && !safe_stop_indication_o)
        else $error("status on during failure");

    // One channel open: stopped, healthy, no safe status, blank display
    a_one_open: assert property (
        (power_ok_i && !fault_i && (a_closed != b_closed))
        |=> safety_health_status_o && !safe_stop_indication_o
        && !drive_en_o && safety_fault_code_o == `DCSS_CODE_NONE)
        else $error("one-open state wrong");

    // Each failure kind has its own display code
    a_fault_code: assert property (
        (power_ok_i && fault_i) |=> safety_fault_code_o
        == `DCSS_CODE_FAULT0 + {1'b0, $past(fault_kind_i)})
        else $error("wrong fault code");

    // Without power nothing is shown and the drive stays off
    a_power_off: assert property (
        !power_ok_i |=> !drive_en_o
        && safety_fault_code_o == `DCSS_CODE_NONE)
        else $error("output active without power");

    // The safe-stop code and the safe status always travel together
    a_stop_code: assert property (
        (safety_fault_code_o == `DCSS_CODE_SAFE_STOP)
        == safe_stop_indication_o)
        else $error("safe-stop code mismatch");

    // Positive selection copies the safe status to the terminal
    a_term_pos: assert property (
        $past(term_sel_i) == `DCSS_SEL_POS
        |-> term_o == safe_stop_indication_o)
        else $error("positive terminal sense wrong");

    // Negative selection inverts it; reset values are not a selection
    a_term_neg: assert property (
        $past(rstn_i) && $past(term_sel_i) == `DCSS_SEL_NEG
        |-> term_o != safe_stop_indication_o)
        else $error("negative terminal sense wrong");

    // Any other code leaves the terminal non-conducting
    a_term_off: assert property (
        $past(term_sel_i) != `DCSS_SEL_POS
        && $past(term_sel_i) != `DCSS_SEL_NEG |-> !term_o)
        else $error("unselected terminal conducting");

    // A channel may only read closed after its contact was closed
    a_chan_stable: assert property (
        $rose(a_closed) |-> $past(safety_channel_a_i, 3))
        else $error("channel a rose without input");

    // Same for channel b
    a_chan_b_stable: assert property (
        $rose(b_closed) |-> $past(safety_channel_b_i, 3))
        else $error("channel b rose without input");

    // Reset must hold every output safe, so this one is never disabled
    a_reset_safe: assert property (
        disable iff (1'b0)
        !rstn_i |-> !drive_en_o && !safety_health_status_o
        && !safe_stop_indication_o && !term_o)
        else $error("outputs unsafe in reset");

    // Main scenarios: run, safe stop, fault, one open, inverted terminal
    c_run: cover property ($rose(drive_en_o));
    c_stop: cover property ($rose(safe_stop_indication_o));
    c_fault: cover property (st.mode == DCSS_FAULT);
    c_one_open: cover property (safety_health_status_o
        && !safe_stop_indication_o && !drive_en_o);
    c_term_neg: cover property (term_o && $past(term_sel_i) == `DCSS_SEL_NEG);
endmodule

// >>> tb/dcss_relay_model.sv
// Behavioural model of the external two-channel safety relay
module dcss_relay_model #(
    parameter int HOLD = 12
)(
    input wire logic core_clk_i, // Bench clock
    input wire logic req_a_i, // Wanted level of channel a
    input wire logic req_b_i, // Wanted level of channel b
    input wire logic glitch_i, // Deliberate short drop on channel a
    output logic safety_channel_a_o, // Contact a, 1 = shorted
    output logic safety_channel_b_o // Contact b, 1 = shorted
);
    timeunit 1ns;
    timeprecision 1ps;
    logic a_q = 1'b0;
    logic b_q = 1'b0;
    int age = 0;
    // A new state passes only once the old one was held long enough
    always @(negedge core_clk_i)
    begin
        if (age >= HOLD && (req_a_i != a_q || req_b_i != b_q))
        begin
            a_q <= req_a_i;
            b_q <= req_b_i;
            age <= 0;
        end
        else
            age <= age + 1;
    end
    // Glitch breaks the hold time on purpose, only when the bench asks
    assign safety_channel_a_o = a_q & ~glitch_i;
    assign safety_channel_b_o = b_q;
endmodule

// >>> tb/dcss_safe_stop_tb_top.sv
// Self-checking bench for the dual-channel safe stop
`include "dcss_defs.svh"
module dcss_safe_stop_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QUAL = 8;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b1;
    logic power_ok_i = 1'b1;
    logic fault_i = 1'b0;
    logic [1:0] fault_kind_i = 2'h0;
    logic [7:0] term_sel_i = 8'h50;
    logic req_a = 1'b1;
    logic req_b = 1'b1;
    logic glitch = 1'b0;
    logic ch_a, ch_b, drive_en_o, safe_o, health_o, term_o;
    logic [2:0] code_o;
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 32'hE694;
    int r;
    int exp_q[$];
    // Clock at 100 MHz
    always #5 core_clk_i = ~core_clk_i;
    dcss_relay_model #(.HOLD(12)) relay (.core_clk_i(core_clk_i),
        .req_a_i(req_a), .req_b_i(req_b), .glitch_i(glitch),
        .safety_channel_a_o(ch_a), .safety_channel_b_o(ch_b));
    dcss_safe_stop #(.QUAL_CYCLES(QUAL)) DUT (.core_clk_i(core_clk_i),
        .rstn_i(rstn_i), .power_ok_i(power_ok_i),
        .safety_channel_a_i(ch_a), .safety_channel_b_i(ch_b),
        .fault_i(fault_i), .fault_kind_i(fault_kind_i),
        .term_sel_i(term_sel_i), .drive_en_o(drive_en_o),
        .safe_stop_indication_o(safe_o),
        .safety_health_status_o(health_o), .term_o(term_o),
        .safety_fault_code_o(code_o));
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Rule model: queues drive, safe, health, code and term, in that order
    task automatic model_expect;
        int en;
        int safe;
        int code;
        int term;
        en = (power_ok_i && !fault_i) ? 1 : 0;
        safe = (en == 1 && !req_a && !req_b) ? 1 : 0;
        code = `DCSS_CODE_NONE;
        if (power_ok_i && fault_i)
            code = `DCSS_CODE_FAULT0 + fault_kind_i;
        else if (safe == 1)
            code = `DCSS_CODE_SAFE_STOP;
        term = 0;
        if (term_sel_i == `DCSS_SEL_POS)
            term = safe;
        else if (term_sel_i == `DCSS_SEL_NEG)
            term = 1 - safe;
        exp_q.delete();
        exp_q.push_back((en == 1 && req_a && req_b) ? 1 : 0);
        exp_q.push_back(safe);
        exp_q.push_back(en);
        exp_q.push_back(code);
        exp_q.push_back(term);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog: the sequence needs about 1300 cycles
    initial
    begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    // Main sequence: reset, random steady states, then a short glitch
    initial
    begin
        // Assert reset through the scheduler so the flops see a real edge
        rstn_i <= 1'b0;
        repeat (3) @(negedge core_clk_i);
        check("drive_rst", drive_en_o, 0);
        check("health_rst", health_o, 0);
        check("safe_rst", safe_o, 0);
        check("term_rst", term_o, 0);
        repeat (3) @(negedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (60)
        begin
            @(negedge core_clk_i);
            r = $random(seed);
            power_ok_i <= r[3:0] != 4'h0;
            fault_i <= r[7:5] == 3'h0;
            fault_kind_i <= r[9:8];
            req_a <= r[10];
            req_b <= r[11];
            term_sel_i <= r[13:12] == 2'h0 ? 8'h50 :
                r[13:12] == 2'h1 ? 8'hB4 : r[21:14];
            repeat (20) @(negedge core_clk_i);
            model_expect();
            check("drive_en", drive_en_o, exp_q.pop_front());
            check("safe_stop", safe_o, exp_q.pop_front());
            check("health", health_o, exp_q.pop_front());
            check("code", code_o, exp_q.pop_front());
            if (power_ok_i)
                check("term", term_o, exp_q.pop_front());
        end
        power_ok_i <= 1'b1;
        fault_i <= 1'b0;
        req_a <= 1'b1;
        req_b <= 1'b1;
        repeat (20) @(negedge core_clk_i);
        glitch <= 1'b1;
        repeat (4) @(negedge core_clk_i);
        glitch <= 1'b0;
        repeat (16)
        begin
            @(negedge core_clk_i);
            check("drive_glitch", drive_en_o, 1);
        end
        report_and_stop();
    end
endmodule
